// ===== logic/hlt_defines.vh
// Constants for the hardware limit timer: register map, field layout,
// reset values and mode codes.
// Assumes it is included by bare name from every design file that needs it.
`ifndef HLT_DEFINES_VH
`define HLT_DEFINES_VH

// APB register byte offsets
`define HLT_ADDR_W 12
`define HLT_OFF_CTRL 12'h000
`define HLT_OFF_PERIOD 12'h004
`define HLT_OFF_COUNT 12'h008
`define HLT_OFF_STATUS 12'h00c

// Control register fields
`define HLT_CTRL_RUN 0
`define HLT_CTRL_MODE_LO 8
`define HLT_CTRL_MODE_HI 12

// Status register fields
`define HLT_STAT_COUNTING 0
`define HLT_STAT_STARTED 1
`define HLT_STAT_TRIG 2
`define HLT_STAT_HELD 3

// Widths and reset values
`define HLT_CNT_W 8
`define HLT_CNT_ONE 8'h01
`define HLT_MODE_W 5
`define HLT_CNT_ZERO 8'h00
`define HLT_PERIOD_RST 8'hff
`define HLT_MODE_RST 5'h00
`define HLT_DATA_ZERO 32'h0000_0000

// Mode field split and APB byte lanes
`define HLT_MODE_UP_HI 4
`define HLT_MODE_UP_LO 3
`define HLT_MODE_LO_HI 2
`define HLT_MODE_LO_LO 0
`define HLT_LANE_LOW 0
`define HLT_LANE_MODE 1

// Mode upper field (mode bits 4:3)
`define HLT_UP_FREE 2'h0
`define HLT_UP_ONESHOT 2'h1
`define HLT_UP_MONO 2'h2

// Mode lower field (mode bits 2:0)
`define HLT_LO_0 3'h0
`define HLT_LO_1 3'h1
`define HLT_LO_2 3'h2
`define HLT_LO_3 3'h3
`define HLT_LO_4 3'h4
`define HLT_LO_5 3'h5
`define HLT_LO_6 3'h6
`define HLT_LO_7 3'h7

`endif

// ===== logic/hlt_edge.v
// Edge detector on a synchronised level: one-cycle rise and fall pulses.
// Assumes the input is already in the pclk domain.
`timescale 1ns/1ps
`default_nettype none

module hlt_edge (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Level in, edge pulses out
    input wire level_in,
    output wire rise,
    output wire fall
);

    reg prev_reg;

    // Previous sample of the level
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= level_in;
        end
    end

    // Edge pulses from the change between samples
    assign rise = level_in & ~prev_reg;
    assign fall = ~level_in & prev_reg;

endmodule

`default_nettype wire

// ===== logic/hlt_sync2.v
// Two flip-flop synchroniser for one level from outside the pclk domain.
// Assumes the input is a slow level compared with pclk.
`timescale 1ns/1ps
`default_nettype none

module hlt_sync2 (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Level in and out
    input wire async_in,
    output reg sync_out
);

    reg meta_reg;

    // First stage feeds only the second stage
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// ===== logic/hlt_timer.v
// Hardware limit timer: 8-bit period counter whose start, reset and stop
// come from a 5-bit mode, a software run bit and an external trigger.
// Assumes an APB master on pclk and an asynchronous trigger pin.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "hlt_defines.vh"

module hlt_timer (
    // APB clock and reset
    input wire pclk,
    input wire presetn,
    // APB request
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`HLT_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    // APB answer
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // External reset/trigger pin
    input wire ext_reset_trigger,
    // Timer state
    output reg [`HLT_CNT_W-1:0] count_value,
    output reg run_enable,
    output reg counting,
    output reg period_match
);

    // Register state
    reg [`HLT_MODE_W-1:0] mode_reg;
    reg [`HLT_CNT_W-1:0] period_limit;
    reg started_reg;

    // Next values
    reg [`HLT_CNT_W-1:0] count_next;
    reg run_next;
    reg started_next;
    reg counting_next;
    reg match_next;

    // Decoded mode and trigger terms
    wire trig;
    wire trig_rise;
    wire trig_fall;
    wire [1:0] mode_up;
    wire [2:0] mode_lo;
    reg start_edge;
    reg reset_cond;
    reg count_en;
    reg edge_start;
    reg hold_stopped;
    reg one_shot_stop;
    reg mono_stop;
    reg valid_mode;

    // APB decode
    wire apb_access;
    wire apb_write;
    wire addr_ctrl;
    wire addr_period;
    wire addr_count;
    wire addr_status;
    wire addr_hit;
    reg [31:0] rd_mux;

    assign mode_up = mode_reg[`HLT_MODE_UP_HI:`HLT_MODE_UP_LO];
    assign mode_lo = mode_reg[`HLT_MODE_LO_HI:`HLT_MODE_LO_LO];

    // Trigger pin crosses into pclk before any logic looks at it
    hlt_sync2 u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(ext_reset_trigger),
        .sync_out(trig)
    );

    // Rising and falling edges of the synchronised trigger
    hlt_edge u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .level_in(trig),
        .rise(trig_rise),
        .fall(trig_fall)
    );

    // Access phase of a transfer, taken when the slave answers
    assign apb_access = psel & penable & pready;
    assign apb_write = apb_access & pwrite;
    assign addr_ctrl = (paddr == `HLT_OFF_CTRL);
    assign addr_period = (paddr == `HLT_OFF_PERIOD);
    assign addr_count = (paddr == `HLT_OFF_COUNT);
    assign addr_status = (paddr == `HLT_OFF_STATUS);
    assign addr_hit = addr_ctrl | addr_period | addr_count | addr_status;

    // Mode decode: what starts, what resets and whether the count may run
    always @* begin
        start_edge = 1'b0;
        reset_cond = 1'b0;
        count_en = 1'b0;
        edge_start = 1'b0;
        hold_stopped = 1'b0;
        one_shot_stop = 1'b0;
        mono_stop = 1'b0;
        valid_mode = 1'b1;
        case (mode_up)
            `HLT_UP_FREE: begin
                case (mode_lo)
                    `HLT_LO_0: count_en = run_enable;
                    `HLT_LO_1: count_en = run_enable & trig;
                    `HLT_LO_2: count_en = run_enable & ~trig;
                    `HLT_LO_3: begin
                        count_en = run_enable;
                        reset_cond = trig_rise | trig_fall;
                    end
                    `HLT_LO_4: begin
                        count_en = run_enable;
                        reset_cond = trig_rise;
                    end
                    `HLT_LO_5: begin
                        count_en = run_enable;
                        reset_cond = trig_fall;
                    end
                    `HLT_LO_6: begin
                        reset_cond = ~trig;
                        count_en = run_enable & trig;
                    end
                    `HLT_LO_7: begin
                        reset_cond = trig;
                        count_en = run_enable & ~trig;
                    end
                    default: count_en = 1'b0;
                endcase
            end
            `HLT_UP_ONESHOT: begin
                one_shot_stop = 1'b1;
                case (mode_lo)
                    `HLT_LO_0: count_en = run_enable;
                    `HLT_LO_1: begin
                        edge_start = 1'b1;
                        start_edge = trig_rise;
                    end
                    `HLT_LO_2: begin
                        edge_start = 1'b1;
                        start_edge = trig_fall;
                    end
                    `HLT_LO_3: begin
                        edge_start = 1'b1;
                        start_edge = trig_rise | trig_fall;
                    end
                    `HLT_LO_4: begin
                        edge_start = 1'b1;
                        start_edge = trig_rise;
                        reset_cond = trig_rise & started_reg;
                    end
                    `HLT_LO_5: begin
                        edge_start = 1'b1;
                        start_edge = trig_fall;
                        reset_cond = trig_fall & started_reg;
                    end
                    `HLT_LO_6: begin
                        edge_start = 1'b1;
                        start_edge = trig_rise;
                        reset_cond = ~trig;
                    end
                    `HLT_LO_7: begin
                        edge_start = 1'b1;
                        start_edge = trig_fall;
                        reset_cond = trig;
                    end
                    default: count_en = 1'b0;
                endcase
                if (edge_start) begin
                    count_en = run_enable & started_reg & ~reset_cond;
                end
            end
            `HLT_UP_MONO: begin
                case (mode_lo)
                    `HLT_LO_1: begin
                        mono_stop = 1'b1;
                        edge_start = 1'b1;
                        start_edge = trig_rise;
                    end
                    `HLT_LO_2: begin
                        mono_stop = 1'b1;
                        edge_start = 1'b1;
                        start_edge = trig_fall;
                    end
                    `HLT_LO_3: begin
                        mono_stop = 1'b1;
                        edge_start = 1'b1;
                        start_edge = trig_rise | trig_fall;
                    end
                    `HLT_LO_6: begin
                        one_shot_stop = 1'b1;
                        hold_stopped = 1'b1;
                        reset_cond = ~trig;
                        count_en = run_enable & trig;
                    end
                    `HLT_LO_7: begin
                        one_shot_stop = 1'b1;
                        hold_stopped = 1'b1;
                        reset_cond = trig;
                        count_en = run_enable & ~trig;
                    end
                    default: valid_mode = 1'b0;
                endcase
                if (edge_start) begin
                    count_en = run_enable & started_reg;
                end
            end
            default: valid_mode = 1'b0;
        endcase
        if (!valid_mode) begin
            count_en = 1'b0;
        end
    end

    // Counter, run bit and start latch for the next clock
    always @* begin
        count_next = count_value;
        run_next = run_enable;
        started_next = started_reg;
        match_next = 1'b0;
        counting_next = count_en;
        // Start latch only takes an edge while run is already set
        if (!run_enable || !edge_start) begin
            started_next = 1'b0;
        end else if (start_edge) begin
            started_next = 1'b1;
        end
        if (reset_cond && valid_mode) begin
            count_next = `HLT_CNT_ZERO;
        end else if (hold_stopped && !run_enable) begin
            count_next = `HLT_CNT_ZERO;
        end else if (count_en) begin
            if (count_value == period_limit) begin
                count_next = `HLT_CNT_ZERO;
                match_next = 1'b1;
                if (one_shot_stop) begin
                    run_next = 1'b0;
                    started_next = 1'b0;
                end
                if (mono_stop) begin
                    started_next = 1'b0;
                end
            end else begin
                count_next = count_value + `HLT_CNT_ONE;
            end
        end
        // Software writes to the timer registers
        if (apb_write && addr_ctrl && pstrb[`HLT_LANE_LOW]) begin
            run_next = pwdata[`HLT_CTRL_RUN];
            if (!pwdata[`HLT_CTRL_RUN]) begin
                started_next = 1'b0;
            end
        end
        if (apb_write && addr_count && pstrb[`HLT_LANE_LOW]) begin
            count_next = pwdata[`HLT_CNT_W-1:0];
        end
    end

    // Timer state registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_value <= `HLT_CNT_ZERO;
            run_enable <= 1'b0;
            started_reg <= 1'b0;
            counting <= 1'b0;
            period_match <= 1'b0;
        end else begin
            count_value <= count_next;
            run_enable <= run_next;
            started_reg <= started_next;
            counting <= counting_next;
            period_match <= match_next; // One-cycle pulse on a match
        end
    end

    // Mode and period registers, written by software only
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= `HLT_MODE_RST;
            period_limit <= `HLT_PERIOD_RST;
        end else begin
            if (apb_write && addr_ctrl && pstrb[`HLT_LANE_MODE]) begin
                mode_reg <= pwdata[`HLT_CTRL_MODE_HI:`HLT_CTRL_MODE_LO];
            end
            if (apb_write && addr_period && pstrb[`HLT_LANE_LOW]) begin
                period_limit <= pwdata[`HLT_CNT_W-1:0];
            end
        end
    end

    // Read data selection
    always @* begin
        rd_mux = `HLT_DATA_ZERO;
        case (paddr)
            `HLT_OFF_CTRL: begin
                rd_mux[`HLT_CTRL_RUN] = run_enable;
                rd_mux[`HLT_CTRL_MODE_HI:`HLT_CTRL_MODE_LO] = mode_reg;
            end
            `HLT_OFF_PERIOD: rd_mux[`HLT_CNT_W-1:0] = period_limit;
            `HLT_OFF_COUNT: rd_mux[`HLT_CNT_W-1:0] = count_value;
            `HLT_OFF_STATUS: begin
                rd_mux[`HLT_STAT_COUNTING] = counting;
                rd_mux[`HLT_STAT_STARTED] = started_reg;
                rd_mux[`HLT_STAT_TRIG] = trig;
                rd_mux[`HLT_STAT_HELD] = reset_cond & valid_mode;
            end
            default: rd_mux = `HLT_DATA_ZERO;
        endcase
    end

    // APB answer: one wait state, then pready with data and error together
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `HLT_DATA_ZERO;
        end else begin
            if (psel && penable && !pready) begin
                pready <= 1'b1;
                pslverr <= ~addr_hit;
                prdata <= (pwrite || !addr_hit) ? `HLT_DATA_ZERO : rd_mux;
            end else begin
                pready <= 1'b0;
                pslverr <= 1'b0;
                prdata <= `HLT_DATA_ZERO;
            end
        end
    end

endmodule

`default_nettype wire

// ===== verif/hlt_timer_chk.sv
// Checker for the limit timer: APB answer timing and period match effects.
// Assumes it is bound to hlt_timer, one pclk domain.
`timescale 1ns/1ps
`default_nettype none
module hlt_timer_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Timer
    input wire logic ext_reset_trigger,
    input wire logic [7:0] count_value,
    input wire logic run_enable,
    input wire logic counting,
    input wire logic period_match
);
    logic [4:0] mode_reg;
    logic [7:0] per_reg;
    logic rsv;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadow of mode and period from completed writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= 5'h00;
            per_reg <= 8'hff;
        end else if (psel && penable && pready && pwrite) begin
            if (paddr == 12'h000 && pstrb[1]) mode_reg <= pwdata[12:8];
            if (paddr == 12'h004 && pstrb[0]) per_reg <= pwdata[7:0];
        end
    end
    // Codes that must never count
    assign rsv = mode_reg[4:3] == 2'h3 || mode_reg == 5'h10 || mode_reg[4:1] == 4'ha;
    apb_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("no answer after one wait state");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("answer longer than one cycle");
    ready_phase_a: assert property (pready |-> psel && penable)
        else $error("answer outside access phase");
    map_error_a: assert property (pready |-> pslverr == !(paddr inside {12'h000, 12'h004,
        12'h008, 12'h00c})) else $error("error flag does not match address");
    idle_data_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("answer lines busy while idle");
    match_zero_a: assert property (period_match |-> $past(count_value) == $past(per_reg)
        && count_value == 8'h00) else $error("match not at period or not at zero");
    shot_clear_a: assert property (period_match && (mode_reg[4:3] == 2'h1 ||
        mode_reg[4:1] == 4'hb) |-> !run_enable) else $error("run kept after shot");
    mono_keep_a: assert property (period_match && mode_reg[4:2] == 3'h4 |-> run_enable)
        else $error("run lost in monostable");
    rsv_idle_a: assert property (rsv && $stable(mode_reg) |-> !counting)
        else $error("reserved code counts");
    run_off_a: assert property (!run_enable && !$past(run_enable) |-> !counting)
        else $error("counts with run clear");
    gate_low_a: assert property ((mode_reg == 5'h01 && !ext_reset_trigger)[*5]
        |-> !counting) else $error("high gate counts with trigger low");
    held_low_a: assert property ((mode_reg == 5'h06 && !ext_reset_trigger)[*5]
        |-> count_value == 8'h00) else $error("not held in reset");
    edge_reset_a: assert property (mode_reg == 5'h04 && run_enable
        && $rose(ext_reset_trigger) |-> ##[1:6] count_value == 8'h00)
        else $error("rising edge did not reset");
    cover property (period_match && mode_reg[4:3] == 2'h1);
    cover property (period_match && mode_reg[4:2] == 3'h4);
    cover property (pready && pslverr);
endmodule
`default_nettype wire

// ===== verif/hlt_trig_src.sv
// Model of the pin that drives the external trigger.
// Assumes the bench asks for levels at least six cycles apart.
`timescale 1ns/1ps
`default_nettype none
module hlt_trig_src (
    // Clock
    input wire logic pclk,
    // Requested level
    input wire logic want,
    // Trigger pin
    output var logic pin
);
    logic [1:0] hold_reg;
    initial begin
        pin = 1'b0;
        hold_reg = 2'h0;
    end
    // Follow the request, keeping each level three cycles so it is seen
    always @(posedge pclk) begin
        if (hold_reg != 2'h0) begin
            hold_reg <= hold_reg - 2'h1;
        end else if (want != pin) begin
            pin <= want;
            hold_reg <= 2'h2;
        end
    end
endmodule
`default_nettype wire

// ===== verif/tb_hardware_limit_timer_modes.sv
// Testbench for the limit timer: APB tasks, trigger model, answer queue.
// Assumes the checker and trigger model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_hardware_limit_timer_modes;
    logic pclk, presetn, psel, penable, pwrite, want, trig, idle, mono;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic pready, pslverr, run_enable, counting, period_match;
    logic [7:0] count_value, p;
    logic [4:0] c;
    logic [33:0] e;
    logic [33:0] exp_q[$];
    int n_mismatch, checks;
    logic [5:0] nc[9] = '{6'h01, 6'h22, 6'h06, 6'h27, 6'h10, 6'h14, 6'h15, 6'h18, 6'h1f};
    logic [4:0] os[13] = '{5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f,
        5'h16, 5'h17, 5'h11, 5'h12, 5'h13};
    hlt_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_reset_trigger(trig),
        .count_value(count_value), .run_enable(run_enable), .counting(counting),
        .period_match(period_match));
    hlt_trig_src u_src (.pclk(pclk), .want(want), .pin(trig));
    always #5 pclk = ~pclk;
    task automatic chk(input logic [33:0] ex, input logic [33:0] got);
        checks++;
        if (got !== ex) begin
            n_mismatch++;
            $display("wrong value apb answer expected %h seen %h", ex, got);
        end
    endtask
    // One APB transfer; its answer is noted for the monitor
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        input logic err);
        exp_q.push_back(wr ? {1'b0, err, 32'h0} : {1'b1, err, d});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d);
        apb(1'b0, a, d, 1'b0);
    endtask
    task automatic trg(input logic v);
        want <= v;
        repeat (6) @(posedge pclk);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Compare every answer with the oldest note
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : 34'h3_ffff_ffff;
            chk(e, {e[33], pslverr, e[33] ? prdata : 32'h0});
        end
    end
    // Main sequence
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        want = 1'b0;
        p = 8'($urandom(32'h1e6c0e56));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h000, 32'h0);
        rd(12'h004, 32'hff);
        rd(12'h008, 32'h0);
        apb(1'b0, 12'h010, 32'h0, 1'b1);
        wr(12'h008, {24'h0, p});
        rd(12'h008, {24'h0, p});
        wr(12'h008, 32'h0);
        pstrb <= 4'h2;
        wr(12'h004, 32'h0);
        pstrb <= 4'hf;
        rd(12'h004, 32'hff);
        $display("test registers done");
        foreach (nc[i]) begin
            trg(nc[i][5]);
            wr(12'h000, {19'h0, nc[i][4:0], 8'h01});
            repeat (20) @(posedge pclk);
            rd(12'h008, 32'h0);
            wr(12'h000, 32'h0);
        end
        $display("test idle codes done");
        trg(1'b0);
        wr(12'h000, 32'h0401);
        repeat (30) @(posedge pclk);
        trg(1'b1);
        wr(12'h000, 32'h0);
        rd(12'h008, 32'h6);
        wr(12'h008, 32'h0);
        $display("test edge reset done");
        foreach (os[i]) begin
            c = os[i];
            idle = c[2:0] inside {3'h2, 3'h5, 3'h7};
            mono = c[4:2] == 3'h4;
            p = 8'($urandom_range(15, 4));
            wr(12'h004, {24'h0, p});
            trg(!idle);
            trg(idle);
            wr(12'h000, {19'h0, c, 8'h01});
            repeat (10) @(posedge pclk);
            if (c != 5'h08) rd(12'h008, 32'h0);
            trg(!idle);
            repeat (40) @(posedge pclk);
            rd(12'h000, {19'h0, c, 7'h0, mono});
            rd(12'h008, 32'h0);
            trg(idle);
            if (mono) begin
                repeat (40) @(posedge pclk);
                trg(!idle);
                rd(12'h008, 32'h4);
            end
            wr(12'h000, 32'h0);
            wr(12'h008, 32'h0);
        end
        $display("test start codes done");
        print_verdict();
    end
    // Cut a hang short
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        print_verdict();
    end
endmodule
bind hlt_timer hlt_timer_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .ext_reset_trigger, .count_value,
    .run_enable, .counting, .period_match);
`default_nettype wire
